// ===== tmr_consts.svh
// register indices, field positions and reset values of the reload timer
// Contract
// - on overflow the count register reloads from the active reload value
// - reload writes go to a holding buffer, moved to active at enable and at overflow
// - overflow is the count stepping from 0xff back to the reload value
// - with external source selected, each falling edge of the event pin counts one
// - event counting disables the event pin's wake-up function
// - event counting blocks the event pin interrupt and holds its flag at zero
// - pwm starts high, drops when count equals duty, rises again at overflow
// - in pwm the count starts from reload at enable and after overflow
// - pwm period runs from reload to overflow, 0x00 gives 256 steps
// - duty not above reload keeps pwm low for the whole period
// - overflow flag and interrupt request still work while pwm is output
// - pin enable moves the shared pin to pwm, clearing it restores gpio
// - pulse mode bit zero gives a plain timer or continuous pwm
// - one-pulse mode clears pin enable at overflow after a single pulse
// - counter holds while enable is zero, counts each tick while one
// - external select picks the pin, else clock divided 128 down to 1
// - overflow flag is sticky until software clears it
// - mode register bit layout, every bit resets to zero
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH
`define TMR_IDX_MODE   8'hb8
`define TMR_IDX_COUNT  8'hb9
`define TMR_IDX_RELOAD 8'hba
`define TMR_IDX_DUTY   8'hbb
`define TMR_IDX_STATUS 8'hc0
`define TMR_MODE_EN    7
`define TMR_RATE_HI    6
`define TMR_RATE_LO    4
`define TMR_MODE_EXT   3
`define TMR_MODE_INT   2
`define TMR_MODE_PULSE 1
`define TMR_MODE_PIN   0
`define TMR_STAT_OVF   0
`define TMR_STAT_IEN   1
`define TMR_STAT_PIN   2
`define TMR_CNT_FULL   8'hff
`define TMR_REG_RST    8'h00
`define TMR_PRE_MAX    7'h7f
`endif

// ===== tmr_pkg.sv
// shared types of the reload timer
package tmr_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] rate_t;
endpackage : tmr_pkg

// ===== count_tick_if.sv
// prescaler request and tick between timer core and divider
`timescale 1ns/1ps
`default_nettype none
interface count_tick_if;
    tmr_pkg::rate_t rate;
    logic           run;
    logic           tick;
    modport src  (input rate, input run, output tick);
    modport sink (output rate, output run, input tick);
endinterface : count_tick_if
`default_nettype wire

// ===== prescale_tick.sv
// clock divider, 128 down to 1, giving one-cycle count ticks
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.svh"
module prescale_tick #(
    parameter int PRE_W = 7
) (
    input  wire logic   i_clk,
    input  wire logic   i_reset_n,
    count_tick_if.src   port
);
    if (PRE_W != 7)
        $error("prescale_tick: divider must be 7 bits for 1..128");

    logic [PRE_W-1:0] div_cnt;
    logic [PRE_W-1:0] mask;

    // code 000 needs all bits set, code 111 none
    assign mask      = `TMR_PRE_MAX >> port.rate;
    assign port.tick = port.run && ((div_cnt & mask) == mask);

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n || !port.run)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end
endmodule : prescale_tick
`default_nettype wire

// ===== event_pin_sync.sv
// event pin synchroniser with qualified falling edge
`timescale 1ns/1ps
`default_nettype none
module event_pin_sync (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_pin,
    output logic      o_fall
);
    logic s1;
    logic s2;
    logic s3;
    logic level;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
        end
        else
        begin
            s1 <= i_pin;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // a change counts only once two stages agree
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
        begin
            level  <= 1'b1;
            o_fall <= 1'b0;
        end
        else
        begin
            if (s2 == s3)
                level <= s2;
            o_fall <= level && !s2 && !s3;
        end
    end
endmodule : event_pin_sync
`default_nettype wire

// ===== timer_reload_pwm_event_counter.sv
// 8-bit reload timer with pwm, one-pulse and event count, wishbone slave
//
// Decided for this implementation: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tmr_consts.svh"
module timer_reload_pwm_event_counter #(
    parameter int ADR_W = 12
) (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [ADR_W-1:0] i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    input  wire logic        i_event_pin,
    input  wire logic        i_gpio_wake_req,
    input  wire logic        i_gpio_event_irq,
    input  wire logic        i_gpio_out,
    input  wire logic        i_gpio_oe,
    output logic             o_pin_o,
    output logic             o_pin_oe,
    output logic             o_wake_req,
    output logic             o_overflow_irq,
    output logic             o_event_pin_irq
);
    if (ADR_W < 10)
        $error("timer: address must reach index 0xc0");

    tmr_pkg::byte_t timer_mode_ctl;
    tmr_pkg::byte_t count_value;
    tmr_pkg::byte_t reload_hold;
    tmr_pkg::byte_t reload_active;
    tmr_pkg::byte_t pwm_duty_value;
    tmr_pkg::byte_t wdat;
    logic           overflow_flag;
    logic           overflow_irq_enable;
    logic           event_pin_irq_flag;
    logic           pwm_level;
    logic           run_d;
    logic           ack;
    logic [31:0]    rdat;
    logic           wb_req;
    logic           wr;
    logic           timer_run_enable;
    logic           external_source_select;
    logic           one_pulse_mode;
    logic           pwm_pin_enable;
    logic           ev_fall;
    logic           tick;
    logic           start;
    logic           ovf;
    logic           wr_mode;
    logic           wr_count;
    logic           wr_status;
    logic           clr_ovf;
    logic           clr_pin;

    function automatic logic hit(input logic [ADR_W-1:0] adr, input tmr_pkg::byte_t idx);
        hit = (adr == ADR_W'({idx, 2'b00}));
    endfunction : hit

    count_tick_if tk ();

    prescale_tick #(
        .PRE_W (7)
    ) u_prescale (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .port      (tk.src)
    );

    event_pin_sync u_event_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_pin     (i_event_pin),
        .o_fall    (ev_fall)
    );

    assign timer_run_enable       = timer_mode_ctl[`TMR_MODE_EN];
    assign external_source_select = timer_mode_ctl[`TMR_MODE_EXT];
    assign one_pulse_mode         = timer_mode_ctl[`TMR_MODE_PULSE];
    assign pwm_pin_enable         = timer_mode_ctl[`TMR_MODE_PIN];

    // the internal select bit picks between two rates that are both i_clk here
    assign tk.rate = timer_mode_ctl[`TMR_RATE_HI:`TMR_RATE_LO];
    assign tk.run  = timer_run_enable && !external_source_select;

    assign tick  = timer_run_enable && (external_source_select ? ev_fall : tk.tick);
    assign start = timer_run_enable && !run_d;
    assign ovf   = tick && !start && (count_value == `TMR_CNT_FULL);

    // bus: one wait state, write lands on the edge that sees ack
    assign wb_req    = i_wb_cyc && i_wb_stb;
    assign wr        = wb_req && ack && i_wb_we && i_wb_sel[0];
    assign wdat      = i_wb_dat[7:0];
    assign wr_mode   = wr && hit(i_wb_adr, `TMR_IDX_MODE);
    assign wr_count  = wr && hit(i_wb_adr, `TMR_IDX_COUNT);
    assign wr_status = wr && hit(i_wb_adr, `TMR_IDX_STATUS);
    assign clr_ovf   = wr_status && !wdat[`TMR_STAT_OVF];
    assign clr_pin   = wr_status && !wdat[`TMR_STAT_PIN];
    assign o_wb_ack  = ack;
    assign o_wb_dat  = rdat;

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            ack <= 1'b0;
        else
            ack <= wb_req && !ack;
    end

    // reload is write-only and reads as zero, unmapped reads as zero
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            rdat <= '0;
        else if (wb_req && !ack)
        begin
            rdat <= '0;
            if (hit(i_wb_adr, `TMR_IDX_MODE))
                rdat[7:0] <= timer_mode_ctl;
            else if (hit(i_wb_adr, `TMR_IDX_COUNT))
                rdat[7:0] <= count_value;
            else if (hit(i_wb_adr, `TMR_IDX_DUTY))
                rdat[7:0] <= pwm_duty_value;
            else if (hit(i_wb_adr, `TMR_IDX_STATUS))
            begin
                rdat[`TMR_STAT_OVF] <= overflow_flag;
                rdat[`TMR_STAT_IEN] <= overflow_irq_enable;
                rdat[`TMR_STAT_PIN] <= event_pin_irq_flag;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            run_d <= 1'b0;
        else
            run_d <= timer_run_enable;
    end

    // a software write in the overflow cycle wins, so a re-arm is not lost
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            timer_mode_ctl <= `TMR_REG_RST;
        else if (wr_mode)
            timer_mode_ctl <= wdat;
        else if (ovf && one_pulse_mode && pwm_pin_enable)
            timer_mode_ctl[`TMR_MODE_PIN] <= 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            reload_hold <= `TMR_REG_RST;
        else if (wr && hit(i_wb_adr, `TMR_IDX_RELOAD))
            reload_hold <= wdat;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            reload_active <= `TMR_REG_RST;
        else if (start || ovf)
            reload_active <= reload_hold;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            pwm_duty_value <= `TMR_REG_RST;
        else if (wr && hit(i_wb_adr, `TMR_IDX_DUTY))
            pwm_duty_value <= wdat;
    end

    // next period starts from the value that just became active
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            count_value <= `TMR_REG_RST;
        else if (wr_count)
            count_value <= wdat;
        else if (start || ovf)
            count_value <= reload_hold;
        else if (tick)
            count_value <= count_value + 8'h01;
    end

    // high only when duty lies inside the period, else low throughout
    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            pwm_level <= 1'b0;
        else if (!timer_run_enable)
            pwm_level <= 1'b0;
        else if (start || ovf)
            pwm_level <= (pwm_duty_value > reload_hold);
        else if (tick && (count_value + 8'h01 == pwm_duty_value))
            pwm_level <= 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            overflow_flag <= 1'b0;
        else if (ovf)
            overflow_flag <= 1'b1;
        else if (clr_ovf)
            overflow_flag <= 1'b0;
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            overflow_irq_enable <= 1'b0;
        else if (wr_status)
            overflow_irq_enable <= wdat[`TMR_STAT_IEN];
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_reset_n)
            event_pin_irq_flag <= 1'b0;
        else if (external_source_select)
            event_pin_irq_flag <= 1'b0;
        else if (i_gpio_event_irq)
            event_pin_irq_flag <= 1'b1;
        else if (clr_pin)
            event_pin_irq_flag <= 1'b0;
    end

    assign o_overflow_irq  = overflow_flag && overflow_irq_enable;
    assign o_event_pin_irq = event_pin_irq_flag;
    assign o_wake_req      = i_gpio_wake_req && !external_source_select;
    // gpio settings stay untouched, so clearing the enable restores them
    assign o_pin_o         = pwm_pin_enable ? pwm_level : i_gpio_out;
    assign o_pin_oe        = pwm_pin_enable ? 1'b1 : i_gpio_oe;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    reload_on_ovf_a:
    assert property (ovf && !wr_count |=> count_value == $past(reload_hold))
    else $error("count did not reload at overflow");

    hold_buffer_a:
    assert property (!start && !ovf |=> $stable(reload_active))
    else $error("active reload changed outside overflow");

    ovf_flag_set_a:
    assert property (tick && !start && count_value == `TMR_CNT_FULL |=> overflow_flag)
    else $error("overflow at full scale not flagged");

    ext_count_a:
    assert property (timer_run_enable && external_source_select && ev_fall && !start
                     && !wr_count && count_value != `TMR_CNT_FULL
                     |=> count_value == $past(count_value) + 8'h01)
    else $error("event edge not counted");

    wake_block_a:
    assert property (external_source_select |-> !o_wake_req)
    else $error("wake passed during event count");

    pin_irq_zero_a:
    assert property ($past(external_source_select) |-> !event_pin_irq_flag)
    else $error("event pin flag set during event count");

    pwm_rise_a:
    assert property (ovf && pwm_duty_value > reload_hold |=> pwm_level)
    else $error("pwm not high at period start");

    pwm_low_a:
    assert property ((start || ovf) && pwm_duty_value <= reload_hold |=> !pwm_level)
    else $error("pwm high with duty not above reload");

    pin_mux_a:
    assert property (pwm_pin_enable |-> o_pin_oe && o_pin_o == pwm_level)
    else $error("pin not driven by pwm");

    one_pulse_a:
    assert property (ovf && one_pulse_mode && pwm_pin_enable && !wr_mode
                     |=> !pwm_pin_enable && overflow_flag)
    else $error("one pulse did not stop");

    stopped_a:
    assert property (!timer_run_enable && !wr_count |=> $stable(count_value))
    else $error("count moved while stopped");

    flag_sticky_a:
    assert property (overflow_flag && !clr_ovf |=> overflow_flag)
    else $error("overflow flag lost");

    pwm_fall_a:
    assert property (tick && !start && !ovf && count_value + 8'h01 == pwm_duty_value |=> !pwm_level)
    else $error("pwm did not drop at duty");

    pwm_start_a:
    assert property (start && !wr_count |=> count_value == $past(reload_hold))
    else $error("count did not start from reload");

    count_step_a:
    assert property (tick && !start && !ovf && !wr_count |=> count_value == $past(count_value) + 8'h01)
    else $error("count did not step on tick");

    irq_out_a:
    assert property (ovf && overflow_irq_enable && !wr_status |=> o_overflow_irq)
    else $error("overflow interrupt not requested");

    gpio_restore_a:
    assert property (!pwm_pin_enable |-> o_pin_o == i_gpio_out && o_pin_oe == i_gpio_oe)
    else $error("pin not returned to gpio");

    plain_mode_a:
    assert property (ovf && !one_pulse_mode && !wr_mode |=> $stable(timer_mode_ctl))
    else $error("mode changed at overflow in continuous mode");

    no_early_ovf_a:
    assert property (!ovf && !overflow_flag |=> !overflow_flag)
    else $error("overflow flagged without overflow");

    ext_only_a:
    assert property (external_source_select && !ev_fall && !start && !wr_count
                     |=> $stable(count_value))
    else $error("count moved without event edge");

    pwm_stop_a:
    assert property (!timer_run_enable |=> !pwm_level)
    else $error("pwm high while stopped");

    active_load_a:
    assert property (ovf |=> reload_active == $past(reload_hold))
    else $error("active reload not loaded at overflow");

    fall_once_a:
    assert property (ev_fall |=> !ev_fall)
    else $error("event edge counted twice");
endmodule : timer_reload_pwm_event_counter
`default_nettype wire

// ===== tmr_far_side.sv
// far-side pin model: event source and gpio drive of the shared pins
`timescale 1ns/1ps
`default_nettype none
module tmr_far_side (
    input  wire logic i_clk,
    output logic      o_event_pin,
    output logic      o_gpio_out,
    output logic      o_gpio_oe,
    output logic      o_gpio_wake,
    output logic      o_gpio_irq
);
    logic [3:0] pat;
    logic       irq_on;
    initial
    begin
        pat = 4'h0;
        irq_on = 1'b0;
        o_event_pin = 1'b1;
    end
    // gpio side moves every cycle so a stale passthrough shows up
    always @(posedge i_clk)
        pat <= pat + 4'h1;
    assign o_gpio_out  = pat[0];
    assign o_gpio_oe   = pat[1];
    assign o_gpio_wake = pat[1];
    // gpio interrupt stays quiet until a test opens it, else status reads see its flag
    assign o_gpio_irq  = pat[2] && irq_on;
    // slow pulses: the synchroniser needs several cycles per level
    task automatic pulses(input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            o_event_pin <= 1'b0;
            repeat (3) @(posedge i_clk);
            o_event_pin <= 1'b1;
            repeat (2) @(posedge i_clk);
        end
    endtask : pulses
endmodule : tmr_far_side
`default_nettype wire

// ===== timer_reload_pwm_event_counter_bench.sv
// self-checking bench of the reload timer with pwm and event count
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
    begin n_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module timer_reload_pwm_event_counter_bench;
    logic        clk, reset_n, cyc, stb, we, ack, pin_o, pin_oe, wake, ovf_irq, ev_irq;
    logic [11:0] adr;
    logic [31:0] wdat, rdat;
    logic [7:0]  rd, r, d;
    wire logic   ev_pin, g_out, g_oe, g_wake, g_irq;
    int          num_errors, n_checks, cycles, seed, n, hi, lo, t0, e;
    timer_reload_pwm_event_counter #(.ADR_W(12)) dut (
        .i_clk(clk), .i_reset_n(reset_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
        .i_event_pin(ev_pin), .i_gpio_wake_req(g_wake), .i_gpio_event_irq(g_irq),
        .i_gpio_out(g_out), .i_gpio_oe(g_oe), .o_pin_o(pin_o), .o_pin_oe(pin_oe),
        .o_wake_req(wake), .o_overflow_irq(ovf_irq), .o_event_pin_irq(ev_irq));
    tmr_far_side far (.i_clk(clk), .o_event_pin(ev_pin), .o_gpio_out(g_out),
        .o_gpio_oe(g_oe), .o_gpio_wake(g_wake), .o_gpio_irq(g_irq));
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            num_errors++;
            stop_test();
        end
    end
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int k;
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= {2'b00, idx, 2'b00};
        wdat <= {24'h0, wd};
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (ack !== 1'b1 && k < 40);
        rd = rdat[7:0];
        if (k >= 40)
            num_errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : wb
    task automatic wait_lvl(input logic v, output int k);
        k = 0;
        while (pin_o !== v && k < 700)
        begin
            @(posedge clk);
            k++;
        end
    endtask : wait_lvl
    function automatic int pwm_hi(input logic [7:0] rv, input logic [7:0] dv);
        return (dv > rv) ? int'(dv) - int'(rv) : 0;
    endfunction : pwm_hi
    // overflow puts the count back on reload, not on zero
    function automatic logic [7:0] ev_count(input logic [7:0] rv, input int k);
        logic [7:0] c;
        c = rv;
        repeat (k) c = (c == 8'hff) ? rv : c + 8'h01;
        return c;
    endfunction : ev_count
    task automatic setup(input logic [7:0] rv, input logic [7:0] dv);
        wb(1'b1, 8'hb8, 8'h00);
        wb(1'b1, 8'hb9, rv);
        wb(1'b1, 8'hba, rv);
        wb(1'b1, 8'hbb, dv);
        wb(1'b1, 8'hc0, 8'h02);
    endtask : setup
    initial
    begin
        seed = 32'h792db2b7;
        reset_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 12'h000;
        wdat = 32'h0;
        num_errors = 0;
        n_checks = 0;
        cycles = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        for (int k = 0; k < 6; k++)
        begin
            wb(1'b0, (k == 5) ? 8'h10 : (k == 4) ? 8'hc0 : 8'hb8 + k[7:0], 8'h00);
            `CHK(rd, 8'h00)
        end
        $display("test reset values done");
        for (int k = 0; k < 8; k++)
        begin
            setup(8'h00, 8'h00);
            wb(1'b1, 8'hb8, {1'b1, k[2:0], 4'h0});
            t0 = cycles;
            repeat (200) @(posedge clk);
            wb(1'b0, 8'hb9, 8'h00);
            // start edge and read latency fall inside the measured span
            e = (cycles - t0 - 3) / (128 >> k);
            `CHK(int'(rd) + 2 >= e && int'(rd) <= e + 2, 1'b1)
        end
        wb(1'b1, 8'hb8, 8'h70);
        wb(1'b0, 8'hb9, 8'h00);
        r = rd;
        repeat (50) @(posedge clk);
        wb(1'b0, 8'hb9, 8'h00);
        `CHK(rd, r)
        $display("test prescaler done");
        setup(8'hc0, 8'h00);
        wb(1'b1, 8'hb8, 8'hf0);
        wb(1'b1, 8'hba, 8'h40);
        wb(1'b0, 8'hb9, 8'h00);
        `CHK(rd >= 8'hc0, 1'b1)
        `CHK(ovf_irq, 1'b0)
        n = 0;
        while (ovf_irq !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        wb(1'b0, 8'hb9, 8'h00);
        `CHK(rd >= 8'h40 && rd < 8'h50, 1'b1)
        wb(1'b1, 8'hb8, 8'h00);
        repeat (20) @(posedge clk);
        `CHK(ovf_irq, 1'b1)
        wb(1'b1, 8'hc0, 8'h03);
        wb(1'b0, 8'hc0, 8'h00);
        `CHK(rd, 8'h03)
        wb(1'b1, 8'hc0, 8'h00);
        `CHK(ovf_irq, 1'b0)
        $display("test reload and flag done");
        for (int k = 0; k < 5; k++)
        begin
            r = (k == 0) ? 8'h00 : (k == 1) ? 8'h80 : 8'($random(seed) & 8'h7f);
            d = (k == 4) ? r : 8'(int'(r) + 1 + (($random(seed) & 32'h7fff) % (255 - int'(r))));
            setup(r, d);
            wb(1'b1, 8'hb8, 8'hf1);
            wait_lvl(1'b0, n);
            wait_lvl(1'b1, n);
            if (pwm_hi(r, d) == 0)
                `CHK(n, 700)
            else
            begin
                wait_lvl(1'b0, hi);
                wait_lvl(1'b1, lo);
                `CHK(hi, pwm_hi(r, d))
                `CHK(hi + lo, 256 - int'(r))
            end
            `CHK(ovf_irq, 1'b1)
            wb(1'b0, 8'hb8, 8'h00);
            `CHK(rd, 8'hf1)
            `CHK(pin_oe, 1'b1)
            wb(1'b1, 8'hb8, 8'hf0);
            `CHK(pin_o, g_out)
            `CHK(pin_oe, g_oe)
        end
        $display("test pwm done");
        setup(8'hc0, 8'he0);
        wb(1'b1, 8'hc0, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            wb(1'b1, 8'hb8, 8'hf3);
            repeat (100) @(posedge clk);
            wb(1'b0, 8'hb8, 8'h00);
            `CHK(rd, 8'hf2)
            `CHK(pin_oe, g_oe)
        end
        wb(1'b0, 8'hc0, 8'h00);
        `CHK(rd[0], 1'b1)
        $display("test one pulse done");
        setup(8'hfd, 8'h00);
        wb(1'b1, 8'hc0, 8'h00);
        wb(1'b1, 8'hb8, 8'h88);
        n = 4 + ($random(seed) & 7);
        far.irq_on <= 1'b1;
        fork
            far.pulses(n);
            repeat (6 * n)
            begin
                @(posedge clk);
                `CHK(wake, 1'b0)
                `CHK(ev_irq, 1'b0)
            end
        join
        repeat (8) @(posedge clk);
        wb(1'b0, 8'hb9, 8'h00);
        `CHK(rd, ev_count(8'hfd, n))
        wb(1'b0, 8'hc0, 8'h00);
        `CHK(rd, 8'h01)
        wb(1'b1, 8'hb8, 8'h00);
        `CHK(wake, g_wake)
        repeat (10) @(posedge clk);
        `CHK(ev_irq, 1'b1)
        $display("test event count done");
        stop_test();
    end
endmodule : timer_reload_pwm_event_counter_bench
`default_nettype wire
